// ==== common/itl_pkg.sv ====
// Purpose: Constants and types of the inverse-time current limiter
// Assumes: Currents and levels in units of 0.01 %, times in 0.1 s units
// Notes:   Register offsets are byte addresses on an AXI4-Lite bus
package itl_pkg;
  localparam int unsigned CLK_MHZ      = 50;
  // Register byte offsets
  localparam logic [31:0] A_CTRL       = 32'h0000_0000;
  localparam logic [31:0] A_THRESH     = 32'h0000_0004;
  localparam logic [31:0] A_DELAY      = 32'h0000_0008;
  localparam logic [31:0] A_DOWN       = 32'h0000_000c;
  localparam logic [31:0] A_UP         = 32'h0000_0010;
  localparam logic [31:0] A_STAT       = 32'h0000_0014;
  localparam logic [31:0] A_IRQ_ST     = 32'h0000_0018;
  localparam logic [31:0] A_IRQ_MASK   = 32'h0000_001c;
  localparam logic [31:0] A_LEVEL      = 32'h0000_0020;
  // Control register fields
  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_PM      = 1;
  localparam int unsigned CTRL_QUAD    = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h1;
  // Status register fields
  localparam int unsigned STAT_ACT     = 0;
  localparam int unsigned STAT_ST_LSB  = 4;
  // Interrupt status bits
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_TRIP     = 0;
  localparam int unsigned IRQ_FLOOR    = 1;
  localparam int unsigned IRQ_DONE     = 2;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
  // Settings: reset value, least and greatest
  localparam logic [15:0] THRESH_RST   = 16'h2904;
  localparam logic [15:0] THRESH_MIN   = 16'h1388;
  localparam logic [15:0] THRESH_MAX   = 16'h3a98;
  localparam logic [15:0] DELAY_RST    = 16'h0258;
  localparam logic [15:0] DELAY_MIN    = 16'h0032;
  localparam logic [15:0] DELAY_MAX    = 16'h0258;
  localparam logic [15:0] DOWN_RST     = 16'h0064;
  localparam logic [15:0] DOWN_MIN     = 16'h000a;
  localparam logic [15:0] DOWN_MAX     = 16'h0064;
  localparam logic [15:0] UP_RST       = 16'h04b0;
  localparam logic [15:0] UP_MIN       = 16'h000a;
  localparam logic [15:0] UP_MAX       = 16'h1770;
  // Overload reference levels and quadratic delay
  localparam logic [15:0] REF_STD      = 16'h3a98;
  localparam logic [15:0] REF_QUAD     = 16'h2af8;
  localparam logic [15:0] QUAD_DELAY   = 16'h0258;
  // Timing
  localparam int unsigned FULL_SCALE   = 10000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;
  localparam int unsigned TENTH_US     = 100000;
  localparam int unsigned TICKS_PER_TENTH = TENTH_US / TICK_TIME_US;
  localparam int unsigned STEP_CYCLES  = TENTH_US * CLK_MHZ / FULL_SCALE;
  localparam int unsigned ACC_W        = 40;
  localparam int unsigned PER_W        = 22;
  // Bus answers
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_DOWN = 4'h2,
    S_HOLD = 4'h4,
    S_UP   = 4'h8
  } lim_state_t;

  typedef struct packed {
    logic [2:0]  ctrl;
    logic [15:0] thresh;
    logic [15:0] delay;
    logic [15:0] down;
    logic [15:0] up;
  } cfg_t;

  typedef struct packed {
    cfg_t              cfg;
    lim_state_t        state;
    logic [ACC_W-1:0]  acc;
    logic [15:0]       limit;
    logic              active;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_mask;
    logic              irq;
    logic              aw_rdy;
    logic              w_rdy;
    logic              aw_got;
    logic              w_got;
    logic [31:0]       waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } st_t;
endpackage : itl_pkg

// ==== design/itl_tick.sv ====
// Purpose: Periodic one-cycle tick with a run-time period
// Assumes: Period of at least one cycle
// Notes:   Clear holds the count at zero
`timescale 1ns/1ps
`default_nettype none
module itl_tick #(
  parameter int unsigned W = 22
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         clr,
  input  wire logic [W-1:0] period,
  output logic              tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tk_t;

  tk_t s_q;
  tk_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (clr) begin
      s_d.cnt = '0;
    end else if ({1'b0, s_q.cnt} + (W+1)'(1) >= {1'b0, period}) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : itl_tick
`default_nettype wire

// ==== design/itl_limiter.sv ====
// Purpose: Inverse-time overload current limiter with AXI4-Lite registers
// Assumes: Current inputs come from logic on SYS_CLK, 0.01 % per unit
// Notes:   One accumulator tick per millisecond
//
// Contract
// RL1 - Limiter works in every motor mode except permanent magnet mode.
// RL2 - Current above threshold adds its excess to the accumulator.
// RL3 - Threshold is the settled reduced limit; default 105 %, 50-150 %.
// RL4 - Nominal limit allowed until duration at 150 % expires; 5-60 s.
// RL5 - On expiry the limit starts lowering from the nominal limit. A trip from S_UP lowers from the present limit instead.
// RL6 - Limit falls toward threshold at decay ramp rate; 1-10 s.
// RL7 - After overload, limit rises to nominal at recovery rate; 1-600 s.
// RL8 - Quadratic load mode allows 110 % for 60 s before limiting.
// RL9 - Read-only active flag while reduced limit applies; low after reset.
// RL10 - Present effective limit is reported on a read-only output.
// RL11 - Accumulator drains below threshold; empty means overload removed.
// RL12 - Ramp time spans full scale; fixed step per derived tick.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module itl_limiter #(
  parameter int unsigned TICK_CYCLES = itl_pkg::TICK_CYCLES,
  parameter int unsigned STEP_CYCLES = itl_pkg::STEP_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        ARST_N,
  input  wire logic [31:0] AWADDR,
  input  wire logic [2:0]  AWPROT,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic [2:0]  ARPROT,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic [15:0] MOTOR_CURRENT,
  input  wire logic [15:0] NOMINAL_LIMIT,
  output logic [15:0]      LIMIT_OUT,
  output logic             LIMITER_ACTIVE,
  output logic             IRQ
);
  localparam int unsigned PW = itl_pkg::PER_W;
  localparam int unsigned AW = itl_pkg::ACC_W;

  itl_pkg::st_t       s_q;
  itl_pkg::st_t       s_d;
  logic               ms_tick;
  logic               step_tick;
  logic               ramp_clr;
  logic [PW-1:0]      ramp_per;
  logic [31:0]        waddr_al;
  logic [31:0]        raddr_al;
  logic [31:0]        wv;
  logic [15:0]        ref_lvl;
  logic [15:0]        dly;
  logic [15:0]        excess;
  logic [AW-1:0]      trip;
  logic [AW-1:0]      acc_n;
  logic               run;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [15:0] clamp(
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction : clamp

  itl_tick #(
    .W      (PW)
  ) u_ms_tick (
    .clk    (SYS_CLK),
    .arst_n (ARST_N),
    .clr    (1'b0),
    .period (PW'(TICK_CYCLES)),
    .tick   (ms_tick)
  );

  always_comb begin
    ramp_clr = !(s_q.state == itl_pkg::S_DOWN ||
                 s_q.state == itl_pkg::S_UP);
    if (s_q.state == itl_pkg::S_UP) begin
      ramp_per = PW'(32'(s_q.cfg.up) * STEP_CYCLES); // RL7 RL12
    end else begin
      ramp_per = PW'(32'(s_q.cfg.down) * STEP_CYCLES); // RL6 RL12
    end
  end

  itl_tick #(
    .W      (PW)
  ) u_step_tick (
    .clk    (SYS_CLK),
    .arst_n (ARST_N),
    .clr    (ramp_clr),
    .period (ramp_per),
    .tick   (step_tick)
  );

  always_comb begin
    s_d      = s_q;
    waddr_al = {s_q.waddr[31:2], 2'b00};
    raddr_al = {ARADDR[31:2], 2'b00};
    wv       = '0;

    // Write address and data, taken in either order
    if (AWVALID && s_q.aw_rdy) begin
      s_d.waddr  = AWADDR;
      s_d.aw_got = 1'b1;
      s_d.aw_rdy = 1'b0;
    end
    if (WVALID && s_q.w_rdy) begin
      s_d.wdata = WDATA;
      s_d.wstrb = WSTRB;
      s_d.w_got = 1'b1;
      s_d.w_rdy = 1'b0;
    end

    // Register write once both halves are held
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = itl_pkg::RESP_OKAY;
      unique case (waddr_al)
        itl_pkg::A_CTRL: begin
          wv = merge({29'h0, s_q.cfg.ctrl}, s_q.wdata, s_q.wstrb);
          s_d.cfg.ctrl = wv[2:0];
        end
        itl_pkg::A_THRESH: begin
          wv = merge({16'h0, s_q.cfg.thresh}, s_q.wdata, s_q.wstrb);
          s_d.cfg.thresh = clamp(wv[15:0], itl_pkg::THRESH_MIN,
                                 itl_pkg::THRESH_MAX); // RL3
        end
        itl_pkg::A_DELAY: begin
          wv = merge({16'h0, s_q.cfg.delay}, s_q.wdata, s_q.wstrb);
          s_d.cfg.delay = clamp(wv[15:0], itl_pkg::DELAY_MIN,
                                itl_pkg::DELAY_MAX); // RL4
        end
        itl_pkg::A_DOWN: begin
          wv = merge({16'h0, s_q.cfg.down}, s_q.wdata, s_q.wstrb);
          s_d.cfg.down = clamp(wv[15:0], itl_pkg::DOWN_MIN,
                               itl_pkg::DOWN_MAX); // RL6
        end
        itl_pkg::A_UP: begin
          wv = merge({16'h0, s_q.cfg.up}, s_q.wdata, s_q.wstrb);
          s_d.cfg.up = clamp(wv[15:0], itl_pkg::UP_MIN,
                             itl_pkg::UP_MAX); // RL7
        end
        itl_pkg::A_IRQ_MASK: begin
          wv = merge({29'h0, s_q.irq_mask}, s_q.wdata, s_q.wstrb);
          s_d.irq_mask = wv[2:0];
        end
        itl_pkg::A_STAT, itl_pkg::A_IRQ_ST, itl_pkg::A_LEVEL: begin
          s_d.bresp = itl_pkg::RESP_OKAY;
        end
        default: begin
          s_d.bresp = itl_pkg::RESP_DECERR;
        end
      endcase
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
      s_d.aw_rdy = 1'b1;
      s_d.w_rdy  = 1'b1;
    end

    // Read channel
    if (ARVALID && s_q.ar_rdy) begin
      s_d.ar_rdy = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp  = itl_pkg::RESP_OKAY;
      s_d.rdata  = '0;
      unique case (raddr_al)
        itl_pkg::A_CTRL:     s_d.rdata = {29'h0, s_q.cfg.ctrl};
        itl_pkg::A_THRESH:   s_d.rdata = {16'h0, s_q.cfg.thresh};
        itl_pkg::A_DELAY:    s_d.rdata = {16'h0, s_q.cfg.delay};
        itl_pkg::A_DOWN:     s_d.rdata = {16'h0, s_q.cfg.down};
        itl_pkg::A_UP:       s_d.rdata = {16'h0, s_q.cfg.up};
        itl_pkg::A_STAT: begin
          s_d.rdata[itl_pkg::STAT_ACT] = s_q.active; // RL9
          s_d.rdata[itl_pkg::STAT_ST_LSB +: 4] = s_q.state;
        end
        itl_pkg::A_IRQ_ST: begin
          s_d.rdata  = {29'h0, s_q.irq_st};
          s_d.irq_st = '0;
        end
        itl_pkg::A_IRQ_MASK: s_d.rdata = {29'h0, s_q.irq_mask};
        itl_pkg::A_LEVEL:    s_d.rdata = {16'h0, s_q.limit}; // RL10
        default: begin
          s_d.rresp = itl_pkg::RESP_DECERR;
        end
      endcase
    end
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
      s_d.ar_rdy = 1'b1;
    end

    // Overload reference and permitted duration
    run = s_q.cfg.ctrl[itl_pkg::CTRL_EN] &&
          !s_q.cfg.ctrl[itl_pkg::CTRL_PM]; // RL1
    if (s_q.cfg.ctrl[itl_pkg::CTRL_QUAD]) begin
      ref_lvl = itl_pkg::REF_QUAD; // RL8
      dly     = itl_pkg::QUAD_DELAY; // RL8
    end else begin
      ref_lvl = itl_pkg::REF_STD; // RL4
      dly     = s_q.cfg.delay; // RL4
    end
    if (ref_lvl > s_q.cfg.thresh) begin
      trip = AW'(ref_lvl - s_q.cfg.thresh) * AW'(dly) *
             AW'(itl_pkg::TICKS_PER_TENTH); // RL4
    end else begin
      trip = AW'(1);
    end

    // Accumulator: integrate excess, drain below threshold
    acc_n  = s_q.acc;
    excess = '0;
    if (ms_tick) begin
      if (MOTOR_CURRENT > s_q.cfg.thresh) begin
        excess = MOTOR_CURRENT - s_q.cfg.thresh;
        acc_n  = s_q.acc + AW'(excess); // RL2
      end else begin
        excess = s_q.cfg.thresh - MOTOR_CURRENT;
        if (s_q.acc > AW'(excess)) begin
          acc_n = s_q.acc - AW'(excess); // RL11
        end else begin
          acc_n = '0; // RL11
        end
      end
    end
    s_d.acc = acc_n;

    // Limit state machine
    unique case (s_q.state)
      itl_pkg::S_IDLE: begin
        s_d.limit = NOMINAL_LIMIT;
        if (acc_n >= trip) begin
          s_d.state = itl_pkg::S_DOWN; // RL4
          s_d.limit = NOMINAL_LIMIT; // RL5
          s_d.irq_st[itl_pkg::IRQ_TRIP] = 1'b1;
        end
      end
      itl_pkg::S_DOWN: begin
        if (acc_n == '0) begin
          s_d.state = itl_pkg::S_UP; // RL11
        end else if (s_q.limit <= s_q.cfg.thresh) begin
          s_d.state = itl_pkg::S_HOLD; // RL3
          s_d.irq_st[itl_pkg::IRQ_FLOOR] = 1'b1;
        end else if (step_tick) begin
          s_d.limit = s_q.limit - 16'h1; // RL6 RL12
        end
      end
      itl_pkg::S_HOLD: begin
        if (acc_n == '0) begin
          s_d.state = itl_pkg::S_UP; // RL11
        end
      end
      itl_pkg::S_UP: begin
        if (acc_n >= trip) begin
          s_d.state = itl_pkg::S_DOWN;
          s_d.irq_st[itl_pkg::IRQ_TRIP] = 1'b1;
        end else if (s_q.limit >= NOMINAL_LIMIT) begin
          s_d.state = itl_pkg::S_IDLE; // RL7
          s_d.limit = NOMINAL_LIMIT;
          s_d.irq_st[itl_pkg::IRQ_DONE] = 1'b1;
        end else if (step_tick) begin
          s_d.limit = s_q.limit + 16'h1; // RL7 RL12
        end
      end
    endcase

    if (!run) begin
      s_d.state = itl_pkg::S_IDLE; // RL1
      s_d.acc   = '0;
      s_d.limit = NOMINAL_LIMIT;
    end

    s_d.active = (s_d.state != itl_pkg::S_IDLE); // RL9
    s_d.irq    = |(s_d.irq_st & s_d.irq_mask);
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q            <= '0;
      s_q.cfg.ctrl   <= itl_pkg::CTRL_RST;
      s_q.cfg.thresh <= itl_pkg::THRESH_RST; // RL3
      s_q.cfg.delay  <= itl_pkg::DELAY_RST; // RL4
      s_q.cfg.down   <= itl_pkg::DOWN_RST; // RL6
      s_q.cfg.up     <= itl_pkg::UP_RST; // RL7
      s_q.state      <= itl_pkg::S_IDLE;
      s_q.active     <= 1'b0; // RL9
      s_q.irq_mask   <= itl_pkg::IRQ_MASK_RST;
      s_q.aw_rdy     <= 1'b1;
      s_q.w_rdy      <= 1'b1;
      s_q.ar_rdy     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign AWREADY        = s_q.aw_rdy;
  assign WREADY         = s_q.w_rdy;
  assign BVALID         = s_q.bvalid;
  assign BRESP          = s_q.bresp;
  assign ARREADY        = s_q.ar_rdy;
  assign RVALID         = s_q.rvalid;
  assign RDATA          = s_q.rdata;
  assign RRESP          = s_q.rresp;
  assign LIMIT_OUT      = s_q.limit; // RL10
  assign LIMITER_ACTIVE = s_q.active; // RL9
  assign IRQ            = s_q.irq;
endmodule : itl_limiter
`default_nettype wire

// ==== test/itl_limiter_sva.sv ====
// Purpose: Port assertions of the current limiter
// Assumes: Nominal limit steady, ramp times of at least 1 s
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module itl_limiter_sva (
  input wire logic        SYS_CLK,
  input wire logic        ARST_N,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0]  RRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [15:0] NOMINAL_LIMIT,
  input wire logic [15:0] LIMIT_OUT,
  input wire logic        LIMITER_ACTIVE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY
    |-> ##2 BVALID) else $error("Write not answered");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("Read not answered");
  a_b_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("Write answer dropped");
  a_r_stands: assert property (RVALID && !RREADY
    |=> RVALID && $stable(RDATA) && $stable(RRESP)) else $error("Read dropped");
  a_busy_ready: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("Ready during answer");
  a_idle_tracks: assert property (
    !LIMITER_ACTIVE && !$past(LIMITER_ACTIVE) && $past(ARST_N)
    |-> LIMIT_OUT == $past(NOMINAL_LIMIT)) else $error("Idle limit wrong");
  a_trip_start: assert property (
    $rose(LIMITER_ACTIVE) |-> LIMIT_OUT == NOMINAL_LIMIT)
    else $error("Ramp not from nominal");
  a_down_step: assert property (
    LIMITER_ACTIVE && LIMIT_OUT < $past(LIMIT_OUT)
    |-> LIMIT_OUT == $past(LIMIT_OUT) - 16'h1 ##1 $stable(LIMIT_OUT)[*8])
    else $error("Bad down step");
  a_up_step: assert property (
    LIMITER_ACTIVE && LIMIT_OUT > $past(LIMIT_OUT)
    |-> LIMIT_OUT == $past(LIMIT_OUT) + 16'h1 ##1 $stable(LIMIT_OUT)[*8])
    else $error("Bad up step");
endmodule : itl_limiter_sva
`default_nettype wire

// ==== test/itl_far_end.sv ====
// Purpose: Current measurement and nominal limit source
// Assumes: Raw motor current reported, overshoot not clamped
// Notes:   One cycle measurement latency
`timescale 1ns/1ps
`default_nettype none
module itl_far_end #(
  parameter logic [15:0] NOMINAL = 16'h3a98
) (
  input  wire logic        clk,
  input  wire logic [15:0] demand,
  output logic [15:0]      current,
  output logic [15:0]      nominal
);
  assign nominal = NOMINAL;
  always @(posedge clk) begin
    current <= demand;
  end
endmodule : itl_far_end
`default_nettype wire

// ==== test/itl_limiter_tb.sv ====
// Purpose: Self-checking bench of the current limiter
// Assumes: Shortened tick of 20 cycles and step of 1 cycle
// Notes:   Random overload current from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module itl_limiter_tb;
  localparam int TICK = 20;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic [15:0] demand = 16'h0;
  logic        awready, wready, bvalid, arready, rvalid, active, irq;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata;
  logic [15:0] cur, nominal, limit_out;
  integer      seed = 32'h30a7a0ae;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n;
  logic [31:0] ra [7] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h18, 32'h1c};
  logic [31:0] rv [7] = '{32'h1, 32'h2904, 32'h258, 32'h64, 32'h4b0, 32'h0,
                          32'h0};
  always #10 clk = ~clk;
  itl_far_end itl_far_end_inst (.clk(clk), .demand(demand), .current(cur),
    .nominal(nominal));
  itl_limiter #(.TICK_CYCLES(TICK), .STEP_CYCLES(1)) itl_limiter_inst (
    .SYS_CLK(clk), .ARST_N(arst_n), .AWADDR(awaddr), .AWPROT(3'h0),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .MOTOR_CURRENT(cur), .NOMINAL_LIMIT(nominal),
    .LIMIT_OUT(limit_out), .LIMITER_ACTIVE(active), .IRQ(irq));
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_left;
    logic w_left;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    while (aw_left || w_left) begin
      @(posedge clk);
      if (aw_left && awready) begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_left && wready) begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    r = rresp;
  endtask : rd
  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk({r, rdata}, {2'h0, e});
  endtask : rchk
  task automatic wchk(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] e);
    wr(a, d);
    chk(r, e);
  endtask : wchk
  function automatic int trip_ticks(input int rf, input int th, input int dl,
                                    input int ex);
    return ((rf - th) * dl * 100 + ex - 1) / ex;
  endfunction : trip_ticks
  task automatic trip(input int rf, input int th, input int dl);
    logic [15:0] dv;
    int          t;
    dv = 16'(20000 + $unsigned($random(seed)) % 45536);
    t = trip_ticks(rf, th, dl, int'(dv) - th);
    demand <= dv;
    n = 0;
    while (!active && n < 30000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= (t - 1) * TICK && n <= (t + 2) * TICK, 1'b1);
  endtask : trip
  task automatic wait_idle;
    n = 0;
    while (active && n < 8000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_idle
  initial begin
    #(20 * 80000);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(active, 1'b0);
    chk(limit_out, nominal);
    for (int i = 0; i < 7; i++) rchk(ra[i], rv[i]);
    rd(32'h24);
    chk(r, itl_pkg::RESP_DECERR);
    wchk(32'h24, 32'h0, itl_pkg::RESP_DECERR);
    wchk(itl_pkg::A_THRESH, 32'h1, itl_pkg::RESP_OKAY);
    rchk(itl_pkg::A_THRESH, 32'(itl_pkg::THRESH_MIN));
    wchk(itl_pkg::A_THRESH, 32'hffff, itl_pkg::RESP_OKAY);
    rchk(itl_pkg::A_THRESH, 32'(itl_pkg::THRESH_MAX));
    wr(itl_pkg::A_THRESH, 32'h3a34);
    wr(itl_pkg::A_DELAY, 32'h32);
    wr(itl_pkg::A_DOWN, 32'ha);
    wr(itl_pkg::A_UP, 32'ha);
    wr(itl_pkg::A_IRQ_MASK, 32'h1);
    trip(15000, 14900, 50);
    chk(limit_out, nominal);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr(itl_pkg::A_IRQ_MASK, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    n = 0;
    while (limit_out !== 16'h3a34 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(limit_out, 16'h3a34);
    rchk(itl_pkg::A_STAT, 32'h41);
    rchk(itl_pkg::A_LEVEL, 32'h3a34);
    wchk(itl_pkg::A_STAT, 32'h0, itl_pkg::RESP_OKAY);
    rchk(itl_pkg::A_STAT, 32'h41);
    rchk(itl_pkg::A_IRQ_ST, 32'h3);
    rchk(itl_pkg::A_IRQ_ST, 32'h0);
    demand <= 16'h0;
    wait_idle();
    chk(limit_out, nominal);
    rchk(itl_pkg::A_IRQ_ST, 32'h4);
    wr(itl_pkg::A_CTRL, 32'h3);
    demand <= 16'hffff;
    repeat (1000) @(posedge clk);
    chk({active, limit_out}, {1'b0, nominal});
    demand <= 16'h0;
    wr(itl_pkg::A_CTRL, 32'h5);
    wr(itl_pkg::A_THRESH, 32'h2a94);
    trip(11000, 10900, 600);
    stop_test();
  end
endmodule : itl_limiter_tb
bind itl_limiter itl_limiter_sva itl_limiter_sva_inst (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
  .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
  .NOMINAL_LIMIT(NOMINAL_LIMIT), .LIMIT_OUT(LIMIT_OUT),
  .LIMITER_ACTIVE(LIMITER_ACTIVE));
`default_nettype wire
